/* rtl/spc_counter_windows.sv */
`timescale 1ns/10ps
`default_nettype none

module spc_counter_windows (
   input wire logic sys_clk, // 25 MHz clock.
   input wire logic nrst, // Asynchronous reset, active low.
   input wire logic [7:0] reg_addr, // Register address.
   input wire logic [7:0] reg_wdata, // Write data.
   input wire logic reg_wr, // Write strobe.
   input wire logic reg_rd, // Read strobe.
   output logic [7:0] reg_rdata, // Read data, cycle after strobe.
   input wire spc_pkg::spc_evt_t err_evt, // Error event pulses.
   input wire logic line_rdi_req, // Internal line RDI request.
   input wire logic path_rdi_req, // Internal path RDI request.
   output logic line_remote_defect_tx_gate, // Line RDI sent.
   output logic path_remote_defect_tx_gate, // Path RDI sent.
   output logic irq // Level interrupt.
);

   // --------------------------------------------------------------
   // Address decode
   // --------------------------------------------------------------
   logic wr_rdi, wr_cause, wr_imask, wr_ovf, do_sample;
   logic [4:0] do_clear;
   logic [4:0] win_rd;
   wire logic [4:0] ev;
   wire logic [4:0] ovf_hit;
   wire logic [7:0] win_byte [spc_pkg::NUM_CNT];
   wire logic [1:0] ptr_val [spc_pkg::NUM_CNT];

   assign ev = err_evt;

   // Strobes for each register; windows sit at consecutive offsets.
   always_comb
   begin
      wr_rdi = reg_wr && (reg_addr == spc_pkg::ADDR_RDI_MASK);
      wr_cause = reg_wr && (reg_addr == spc_pkg::ADDR_INT_CAUSE);
      wr_imask = reg_wr && (reg_addr == spc_pkg::ADDR_INT_MASK);
      wr_ovf = reg_wr && (reg_addr == spc_pkg::ADDR_OVFL);
      do_sample = reg_wr && (reg_addr == spc_pkg::ADDR_SAMPLE)
                  && reg_wdata[spc_pkg::SAMPLE_BIT];
      do_clear = 5'h00;
      if (reg_wr && (reg_addr == spc_pkg::ADDR_CLEAR))
      begin
         do_clear = reg_wdata[4:0];
      end
      for (int k = 0; k < spc_pkg::NUM_CNT; k++)
      begin
         win_rd[k] = reg_rd && (reg_addr == spc_pkg::ADDR_WIN_BASE + 8'(k));
      end
   end

   // --------------------------------------------------------------
   // Counters, snapshots and window pointers
   // --------------------------------------------------------------
   for (genvar i = 0; i < spc_pkg::NUM_CNT; i++)
   begin : g_cnt
      localparam logic [19:0] MAX = spc_pkg::WIDE_SEL[i] ?
         spc_pkg::MAX_WIDE : spc_pkg::MAX_NARROW;
      localparam logic [1:0] LAST = spc_pkg::WIDE_SEL[i] ?
         spc_pkg::LAST_WIDE : spc_pkg::LAST_NARROW;
      logic [19:0] cnt_q, cnt_d, snap_q, snap_d;
      logic [1:0] ptr_q, ptr_d;
      logic [7:0] part;

      // Next counter, snapshot and pointer values.
      always_comb
      begin
         cnt_d = cnt_q;
         snap_d = snap_q;
         ptr_d = ptr_q;
         if (do_sample)
         begin
            snap_d = cnt_q;
            cnt_d = 20'h00000;
         end
         if (do_clear[i])
         begin
            cnt_d = 20'h00000;
         end
         if (ev[i])
         begin
            cnt_d = (cnt_d == MAX) ? 20'h00000 : cnt_d + 20'h00001;
         end
         if (win_rd[i])
         begin
            ptr_d = (ptr_q == LAST) ? 2'h0 : ptr_q + 2'h1;
         end
      end

      // Byte chosen by the pointer as it stands before the read.
      always_comb
      begin
         case (ptr_q)
            2'h0: part = snap_q[7:0];
            2'h1: part = snap_q[15:8];
            default: part = {4'h0, snap_q[19:16]};
         endcase
      end

      // Counter state registers.
      always_ff @(posedge sys_clk or negedge nrst)
      begin
         if (!nrst)
         begin
            cnt_q <= 20'h00000;
            snap_q <= 20'h00000;
            ptr_q <= 2'h0;
         end
         else
         begin
            cnt_q <= cnt_d;
            snap_q <= snap_d;
            ptr_q <= ptr_d;
         end
      end

      assign ovf_hit[i] = ev[i] && (cnt_d == MAX);
      assign win_byte[i] = part;
      assign ptr_val[i] = ptr_q;
   end

   // --------------------------------------------------------------
   // Control, interrupt and read-back registers
   // --------------------------------------------------------------
   logic [1:0] rdi_mask_q, rdi_mask_d;
   logic int_mask_q, int_mask_d, cause_q, cause_d;
   logic [4:0] ovf_q, ovf_d;
   logic [7:0] rdata_q, rdata_d;
   logic irq_q, irq_d, lgate_q, lgate_d, pgate_q, pgate_d;

   // Next control state; a set always wins over a write-one clear.
   always_comb
   begin
      rdi_mask_d = rdi_mask_q;
      int_mask_d = int_mask_q;
      if (wr_rdi)
      begin
         rdi_mask_d = reg_wdata[1:0];
      end
      if (wr_imask)
      begin
         int_mask_d = reg_wdata[spc_pkg::INT_OVFL_BIT];
      end
      ovf_d = (ovf_q & ~(wr_ovf ? reg_wdata[4:0] : 5'h00)) | ovf_hit;
      cause_d = (cause_q && !(wr_cause && reg_wdata[spc_pkg::INT_OVFL_BIT]))
                || (|ovf_hit);
      irq_d = cause_d && int_mask_d;
      lgate_d = line_rdi_req && rdi_mask_q[spc_pkg::RDI_LINE_BIT];
      pgate_d = path_rdi_req && rdi_mask_q[spc_pkg::RDI_PATH_BIT];
      rdata_d = 8'h00;
      if (reg_rd)
      begin
         if (reg_addr == spc_pkg::ADDR_INT_CAUSE)
         begin
            rdata_d[spc_pkg::INT_OVFL_BIT] = cause_q;
         end
         else if (reg_addr == spc_pkg::ADDR_INT_MASK)
         begin
            rdata_d[spc_pkg::INT_OVFL_BIT] = int_mask_q;
         end
         else if (reg_addr == spc_pkg::ADDR_RDI_MASK)
         begin
            rdata_d = {6'h00, rdi_mask_q};
         end
         else if (reg_addr == spc_pkg::ADDR_RD_PTR)
         begin
            rdata_d = {1'b0, ptr_val[4][0], ptr_val[3], ptr_val[2][0],
                       ptr_val[1], ptr_val[0][0]};
         end
         else if (reg_addr == spc_pkg::ADDR_OVFL)
         begin
            rdata_d = {3'h0, ovf_q};
         end
         else
         begin
            for (int k = 0; k < spc_pkg::NUM_CNT; k++)
            begin
               if (win_rd[k])
               begin
                  rdata_d = win_byte[k];
               end
            end
         end
      end
   end

   // Control state registers.
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rdi_mask_q <= spc_pkg::RDI_MASK_RST;
         int_mask_q <= spc_pkg::INT_MASK_RST;
         cause_q <= 1'b0;
         ovf_q <= 5'h00;
         rdata_q <= 8'h00;
         irq_q <= 1'b0;
         lgate_q <= 1'b0;
         pgate_q <= 1'b0;
      end
      else
      begin
         rdi_mask_q <= rdi_mask_d;
         int_mask_q <= int_mask_d;
         cause_q <= cause_d;
         ovf_q <= ovf_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
         lgate_q <= lgate_d;
         pgate_q <= pgate_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign irq = irq_q;
   assign line_remote_defect_tx_gate = lgate_q;
   assign path_remote_defect_tx_gate = pgate_q;

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence line_blocked_s;
      line_rdi_req && !rdi_mask_q[spc_pkg::RDI_LINE_BIT];
   endsequence
   sequence b1_quiet_sample_s;
      do_sample && !ev[0] && !do_clear[0];
   endsequence
   sequence b2_top_read_s;
      win_rd[1] && (ptr_val[1] == 2'h2);
   endsequence
   sequence pfar_low_read_s;
      win_rd[4] && (ptr_val[4] == 2'h0) && !do_sample;
   endsequence
   sequence lfar_mid_read_s;
      win_rd[3] && (ptr_val[3] == 2'h1);
   endsequence
   sequence b2_mid_read_s;
      win_rd[1] && (ptr_val[1] == 2'h1) && !do_sample;
   endsequence
   sequence b1_plain_count_s;
      ev[0] && !do_sample && !do_clear[0] && (g_cnt[0].cnt_q != spc_pkg::MAX_NARROW);
   endsequence
   sequence pfar_plain_count_s;
      ev[4] && !do_sample && !do_clear[4] && (g_cnt[4].cnt_q != spc_pkg::MAX_NARROW);
   endsequence

   line_gate_a: assert property (line_blocked_s |=> !line_remote_defect_tx_gate)
      else $error("line RDI sent while masked");
   path_gate_a: assert property ((path_rdi_req && rdi_mask_q[0])
      |=> path_remote_defect_tx_gate)
      else $error("path RDI not sent while enabled");
   mask_upper_a: assert property ((reg_rd && reg_addr == spc_pkg::ADDR_RDI_MASK)
      |=> reg_rdata[7:2] == 6'h00)
      else $error("mask upper bits not zero");
   b1_toggle_a: assert property (win_rd[0] |=> ptr_val[0] != $past(ptr_val[0]))
      else $error("B1 pointer did not toggle");
   b2_wrap_a: assert property (b2_top_read_s |=> ptr_val[1] == 2'h0
      ##0 reg_rdata[7:4] == 4'h0)
      else $error("B2 third read wrong");
   pfar_low_a: assert property (pfar_low_read_s |=> reg_rdata == g_cnt[4].snap_q[7:0])
      else $error("path far low byte wrong");
   sample_copy_a: assert property (b1_quiet_sample_s |=>
      g_cnt[0].snap_q == $past(g_cnt[0].cnt_q) ##0 g_cnt[0].cnt_q == 20'h00000)
      else $error("sample did not copy and clear");
   clear_one_a: assert property ((do_clear[2] && !ev[2]) |=> g_cnt[2].cnt_q == 20'h00000)
      else $error("counter clear failed");
   ovf_flag_a: assert property ((ovf_hit != 5'h00) |=>
      ((ovf_q & $past(ovf_hit)) == $past(ovf_hit)) && cause_q)
      else $error("overflow flag or cause not set");
   wrap_zero_a: assert property ((ev[0] && !do_sample && !do_clear[0]
      && g_cnt[0].cnt_q == spc_pkg::MAX_NARROW) |=> g_cnt[0].cnt_q == 20'h00000)
      else $error("counter did not wrap");
   irq_mask_a: assert property ((cause_q && !int_mask_q) |-> !irq)
      else $error("interrupt passed while masked");

   b3_toggle_a: assert property (win_rd[2] |=> ptr_val[2] != $past(ptr_val[2]))
      else $error("B3 pointer did not toggle");
   lfar_step_a: assert property (lfar_mid_read_s |=> ptr_val[3] == 2'h2)
      else $error("line far pointer did not step");
   pfar_toggle_a: assert property (win_rd[4] |=> ptr_val[4] != $past(ptr_val[4]))
      else $error("path far pointer did not toggle");
   b2_mid_a: assert property (b2_mid_read_s |=> reg_rdata == g_cnt[1].snap_q[15:8])
      else $error("B2 middle byte wrong");
   snap_hold_a: assert property (!do_sample |=> $stable(g_cnt[1].snap_q))
      else $error("snapshot changed without sample");
   sample_zero_a: assert property ((do_sample && !ev[3]) |=> g_cnt[3].cnt_q == 20'h00000)
      else $error("sample did not clear counter");
   b1_count_a: assert property (b1_plain_count_s |=>
      g_cnt[0].cnt_q == $past(g_cnt[0].cnt_q) + 20'h00001)
      else $error("B1 counter did not step");
   pfar_count_a: assert property (pfar_plain_count_s |=>
      g_cnt[4].cnt_q == $past(g_cnt[4].cnt_q) + 20'h00001)
      else $error("path far counter did not step");
   ovf_clear_a: assert property ((wr_ovf && reg_wdata[0] && !ovf_hit[0]) |=> !ovf_q[0])
      else $error("overflow flag not cleared");
   cause_clear_a: assert property ((wr_cause && reg_wdata[spc_pkg::INT_OVFL_BIT]
      && (ovf_hit == 5'h00)) |=> !cause_q)
      else $error("cause bit not cleared");
   irq_open_a: assert property ((cause_q && int_mask_q) |-> irq)
      else $error("interrupt not raised while unmasked");
   rdi_store_a: assert property (wr_rdi |=> rdi_mask_q == $past(reg_wdata[1:0]))
      else $error("mask bits not stored");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not cleared");

endmodule // spc_counter_windows

`default_nettype wire

/* rtl/spc_pkg.sv */
package spc_pkg;

   // --------------------------------------------------------------
   // Sizes
   // --------------------------------------------------------------
   localparam int unsigned NUM_CNT = 5;
   localparam int unsigned CNT_W = 20;
   // Counter indices, also the bit positions in clear and overflow.
   localparam int unsigned IDX_B1 = 0;
   localparam int unsigned IDX_B2 = 1;
   localparam int unsigned IDX_B3 = 2;
   localparam int unsigned IDX_LFAR = 3;
   localparam int unsigned IDX_PFAR = 4;
   // A one marks a 20-bit counter, a zero a 16-bit one.
   localparam logic [4:0] WIDE_SEL = 5'h0a;
   localparam logic [19:0] MAX_WIDE = 20'hfffff;
   localparam logic [19:0] MAX_NARROW = 20'h0ffff;
   localparam logic [1:0] LAST_WIDE = 2'h2;
   localparam logic [1:0] LAST_NARROW = 2'h1;

   // --------------------------------------------------------------
   // Register offsets
   // --------------------------------------------------------------
   localparam logic [7:0] ADDR_INT_CAUSE = 8'h06;
   localparam logic [7:0] ADDR_INT_MASK = 8'h07;
   localparam logic [7:0] ADDR_RDI_MASK = 8'h0c;
   localparam logic [7:0] ADDR_WIN_BASE = 8'h0d;
   localparam logic [7:0] ADDR_RD_PTR = 8'h19;
   localparam logic [7:0] ADDR_SAMPLE = 8'h1b;
   localparam logic [7:0] ADDR_CLEAR = 8'h1c;
   localparam logic [7:0] ADDR_OVFL = 8'h20;

   // --------------------------------------------------------------
   // Field positions and reset values
   // --------------------------------------------------------------
   localparam int unsigned INT_OVFL_BIT = 1;
   localparam int unsigned RDI_LINE_BIT = 1;
   localparam int unsigned RDI_PATH_BIT = 0;
   localparam int unsigned SAMPLE_BIT = 0;
   localparam logic [1:0] RDI_MASK_RST = 2'h0;
   localparam logic INT_MASK_RST = 1'b0;

   // Error events, one-cycle pulses from the overhead monitors.
   typedef struct packed {
      logic path_far;
      logic line_far;
      logic b3;
      logic b2;
      logic b1;
   } spc_evt_t;

endpackage

/* verif/test_spc_counter_windows.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin num_errors++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end

module test_spc_counter_windows;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic sys_clk;
   logic nrst;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   spc_pkg::spc_evt_t err_evt;
   logic line_rdi_req;
   logic path_rdi_req;
   logic line_gate;
   logic path_gate;
   logic irq;
   int num_errors = 0;
   int checks = 0;
   logic [15:0] exp_q[$];
   logic [15:0] note;
   logic rd_pend = 1'b0;
   logic [31:0] seed = 32'h00000061;
   logic [31:0] r;
   int cnt[5];

   spc_counter_windows DUT (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .err_evt(err_evt),
      .line_rdi_req(line_rdi_req),
      .path_rdi_req(path_rdi_req),
      .line_remote_defect_tx_gate(line_gate),
      .path_remote_defect_tx_gate(path_gate),
      .irq(irq)
   );

   // The clock runs at 25 MHz.
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   // Xorshift generator for the random stimulus.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // A write is one strobe cycle, then one idle cycle.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask

   // A read notes its expected byte for the monitor.
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({a, e});
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
   endtask

   // Holds an event vector for n cycles and counts it in the model.
   task automatic pulse(input logic [4:0] v, input int n);
      repeat (n)
      begin
         err_evt <= v;
         for (int i = 0; i < 5; i++)
            cnt[i] += int'(v[i]);
         @(posedge sys_clk);
      end
      err_evt <= '0;
      @(posedge sys_clk);
   endtask

   // Samples, then reads every window completely twice.
   task automatic sample_check();
      int s[5];
      s = cnt;
      wr(spc_pkg::ADDR_SAMPLE, 8'h01);
      cnt = '{default: 0};
      repeat (2)
         for (int i = 0; i < 5; i++)
            for (int p = 0; p < (spc_pkg::WIDE_SEL[i] ? 3 : 2); p++)
               rd(spc_pkg::ADDR_WIN_BASE + 8'(i),
                  8'(s[i] >> (8 * p)) & (p == 2 ? 8'h0f : 8'hff));
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Compares read data in the cycle after each read strobe.
   always @(posedge sys_clk)
   begin
      if (rd_pend)
      begin
         note = exp_q.pop_front();
         `CHK($sformatf("rdata %h", note[15:8]), note[7:0], reg_rdata)
      end
      rd_pend <= reg_rd;
   end

   // Cuts a hang short well past the expected run length.
   initial
   begin
      repeat (90000) @(posedge sys_clk);
      num_errors++;
      end_of_test();
   end

   // -------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------
   initial
   begin
      nrst = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      err_evt = '0;
      line_rdi_req = 1'b0;
      path_rdi_req = 1'b0;
      cnt = '{default: 0};
      repeat (10) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      rd(spc_pkg::ADDR_RDI_MASK, 8'h00);
      rd(spc_pkg::ADDR_RD_PTR, 8'h00);
      rd(spc_pkg::ADDR_OVFL, 8'h00);
      $display("reset test ended");
      // Gates follow requests through each mask setting.
      for (int m = 0; m < 4; m++)
      begin
         r = rnd();
         // Requests are forced on where the gate assertions need them.
         line_rdi_req <= r[0] | (m == 0);
         path_rdi_req <= r[1] | (m == 3);
         wr(spc_pkg::ADDR_RDI_MASK, {r[7:2], 2'(m)});
         rd(spc_pkg::ADDR_RDI_MASK, {6'h00, 2'(m)});
         `CHK("line gate", (r[0] | (m == 0)) & m[1], line_gate)
         `CHK("path gate", (r[1] | (m == 3)) & m[0], path_gate)
      end
      $display("rdi mask test ended");
      // Random events, then sampling.
      repeat (60)
      begin
         r = rnd();
         pulse(r[4:0], 1 + int'(r[6:5]));
      end
      sample_check();
      sample_check();
      $display("count test ended");
      // Per-counter clear, then partial reads and pointer state.
      pulse(5'h1f, 3);
      wr(spc_pkg::ADDR_CLEAR, 8'h05);
      cnt[0] = 0;
      cnt[2] = 0;
      sample_check();
      rd(spc_pkg::ADDR_WIN_BASE, 8'h00);
      rd(spc_pkg::ADDR_WIN_BASE + 8'h01, 8'h03);
      rd(spc_pkg::ADDR_WIN_BASE + 8'h01, 8'h00);
      rd(spc_pkg::ADDR_WIN_BASE + 8'h03, 8'h03);
      rd(spc_pkg::ADDR_WIN_BASE + 8'h04, 8'h03);
      rd(spc_pkg::ADDR_RD_PTR, 8'h55);
      // Finish the partial reads so every pointer is back at zero.
      rd(spc_pkg::ADDR_WIN_BASE, 8'h00);
      rd(spc_pkg::ADDR_WIN_BASE + 8'h01, 8'h00);
      rd(spc_pkg::ADDR_WIN_BASE + 8'h03, 8'h00);
      rd(spc_pkg::ADDR_WIN_BASE + 8'h03, 8'h00);
      rd(spc_pkg::ADDR_WIN_BASE + 8'h04, 8'h00);
      rd(spc_pkg::ADDR_RD_PTR, 8'h00);
      $display("clear test ended");
      // Overflow of the narrow counter at its all-ones value.
      pulse(5'h01, 65534);
      rd(spc_pkg::ADDR_OVFL, 8'h00);
      pulse(5'h01, 1);
      rd(spc_pkg::ADDR_OVFL, 8'h01);
      rd(spc_pkg::ADDR_INT_CAUSE, 8'h02);
      `CHK("irq masked", 1'b0, irq)
      wr(spc_pkg::ADDR_INT_MASK, 8'h02);
      `CHK("irq open", 1'b1, irq)
      pulse(5'h01, 2);
      sample_check();
      wr(spc_pkg::ADDR_OVFL, 8'h01);
      wr(spc_pkg::ADDR_INT_CAUSE, 8'h02);
      rd(spc_pkg::ADDR_OVFL, 8'h00);
      `CHK("irq cleared", 1'b0, irq)
      $display("overflow test ended");
      @(posedge sys_clk);
      end_of_test();
   end
endmodule // test_spc_counter_windows
`default_nettype wire
